//--- logic/iwd_pkg.sv
// Shared constants and types of the instruction word decoder.
// Assumes a single clock domain and program memory that answers within one instruction cycle.
package iwd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Word layout.
   localparam int WORD_W = 14;
   localparam int REG_W = 7;
   localparam int BIT_W = 3;
   localparam int IMM_W = 11;
   localparam int LIT_W = 8;
   localparam int CLASS_MSB = 13;
   localparam int CLASS_LSB = 12;
   localparam int FUNC_MSB = 11;
   localparam int FUNC_LSB = 8;
   localparam int DEST_POS = 7;
   localparam int BIT_LSB = 7;
   localparam int REG_LSB = 0;

   // Timing: oscillator periods in one instruction cycle.
   localparam int PHASES_PER_CYCLE = 4;
   localparam int PHASE_W = $clog2(PHASES_PER_CYCLE);
   localparam int CLK_PERIOD_NS = 100;

   ////////////////////////////////////////////////////////////////////////////////
   // Encodings of the special control words and of the skip groups.
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_IRQ_RETURN = 14'h0009;
   localparam logic [13:0] OP_SLEEP = 14'h0063;
   localparam logic [13:0] OP_KICK = 14'h0064;
   localparam logic [13:0] NOP_MASK = 14'h3F9F;
   localparam logic [3:0] FUNC_DECSKIP = 4'hB;
   localparam logic [3:0] FUNC_INCSKIP = 4'hF;
   localparam logic [1:0] LIT_RETURN = 2'h1;
   localparam logic [6:0] PC_LOW_FILE = 7'h02;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses of aligned words.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_FIELDS = 8'h08;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_POST_BIT = 1;
   localparam int CTRL_IRQ_EN_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h1;

   // Instruction classes follow the two top bits of the word.
   typedef enum logic [1:0] {
      IWD_CLS_BYTE = 2'h0,
      IWD_CLS_BIT = 2'h1,
      IWD_CLS_JUMP = 2'h2,
      IWD_CLS_LIT = 2'h3
   } iwd_class_t;

   typedef enum logic {
      IWD_ST_RUN = 1'b0,
      IWD_ST_SLEEP = 1'b1
   } iwd_state_t;

   typedef struct packed {
      logic skip;
      logic pc;
      logic sleep;
      logic kick;
      logic nop;
   } iwd_flags_t;

endpackage

//--- logic/iwd_phase_gen.sv
// Oscillator phase counter that splits each instruction cycle into four clocks.
// Assumes the caller gates advance with its clock enable and run condition.
module iwd_phase_gen #(
   parameter int PHASES = iwd_pkg::PHASES_PER_CYCLE
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic advance,
   output logic [iwd_pkg::PHASE_W-1:0] phase,
   output logic last
);

   typedef struct packed {
      logic [iwd_pkg::PHASE_W-1:0] cnt;
   } iwd_phase_t;

   iwd_phase_t cur_ff;
   iwd_phase_t nxt_cur;
   localparam logic [iwd_pkg::PHASE_W-1:0] LAST_PHASE = iwd_pkg::PHASE_W'(PHASES - 1);

   // The count stands still whenever advance is low, which is how sleep stops the phases.
   always_comb begin
      nxt_cur = cur_ff;
      if (advance) begin
         nxt_cur.cnt = (cur_ff.cnt == LAST_PHASE) ? '0 : cur_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign phase = cur_ff.cnt;
   assign last = advance && (cur_ff.cnt == LAST_PHASE);

endmodule // iwd_phase_gen

//--- logic/iwd_decoder.sv
// Instruction word decoder with cycle timing, sleep and watchdog clear control, APB registers.
// Assumes program memory on CORE_CLK presents the word at the fetched address before the cycle ends.
//
// Behaviour
// RULE1 - Take each 14-bit word and split it into class code and operand fields.
// RULE2 - Destination bit zero sends result to accumulator, one back to file register.
// RULE3 - Register number field selects one file register from 0x00 to 0x7F.
// RULE4 - Bit position field selects one bit of the addressed 8-bit register.
// RULE5 - Literal and control words yield an eight or eleven bit constant.
// RULE6 - Every instruction takes one instruction cycle unless it skips or changes PC.
// RULE7 - True skip or PC change takes two cycles, the second acting as no-operation.
// RULE8 - One instruction cycle lasts exactly four oscillator clocks.
// RULE9 - Don't-care bits never change the decoded instruction.
// RULE10 - Watchdog kick and power-down clear the watchdog counter and assigned postscaler.
// RULE11 - Interrupt wake with master enable runs the next word, then branches to 0004h.
// RULE12 - Each cycle prefetches the next word; two-cycle words discard that prefetch.
//
// The address map and the APB slave port are this design's own decisions.
module iwd_decoder (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [13:0] PM_WORD,
   input wire logic COND_TRUE,
   input wire logic WAKE_IRQ,
   output logic FETCH_STROBE,
   output logic [1:0] Q_PHASE,
   output logic CYCLE_END,
   output logic EXEC_VALID,
   output logic [13:0] EXEC_WORD,
   output logic [1:0] OP_CLASS,
   output logic [6:0] REG_NUM,
   output logic RESULT_TO_FILE,
   output logic [2:0] BIT_POS,
   output logic [10:0] IMM_CONST,
   output logic IMM_WIDE,
   output logic IS_SKIP,
   output logic CHANGES_PC,
   output logic WATCHDOG_CLEAR,
   output logic POSTSCALER_CLEAR,
   output logic ASLEEP,
   output logic VECTOR_REQ,
   output logic [12:0] VECTOR_ADDR
);

   typedef struct packed {
      iwd_pkg::iwd_state_t st;
      logic [13:0] word;
      logic valid;
      iwd_pkg::iwd_flags_t fl;
      logic run;
      logic post_assign;
      logic irq_en;
      logic vec_pend;
      logic wd_clr;
      logic post_clr;
      logic vec_req;
      logic [31:0] rdata;
      logic slverr;
   } iwd_regs_t;

   iwd_regs_t cur_ff;
   iwd_regs_t nxt_cur;
   logic advance;
   logic cycle_last;
   logic [1:0] phase;
   logic two_cycle;
   logic enter_sleep;
   iwd_pkg::iwd_flags_t fetch_fl;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode of one word into its timing and control flags.
   function automatic iwd_pkg::iwd_flags_t decode(input logic [13:0] w);
      iwd_pkg::iwd_flags_t f;
      logic [1:0] cls;
      logic [3:0] func;
      f = '0;
      cls = w[iwd_pkg::CLASS_MSB:iwd_pkg::CLASS_LSB];
      func = w[iwd_pkg::FUNC_MSB:iwd_pkg::FUNC_LSB];
      // Only the fixed bits are compared, so a set don't-care bit decodes alike.
      f.nop = (w & iwd_pkg::NOP_MASK) == 14'h0000; // see RULE9
      f.sleep = (w == iwd_pkg::OP_SLEEP);
      f.kick = (w == iwd_pkg::OP_KICK);
      case (cls)
         iwd_pkg::IWD_CLS_BYTE: begin
            f.skip = (func == iwd_pkg::FUNC_DECSKIP) || (func == iwd_pkg::FUNC_INCSKIP);
            // A result written to the low PC file moves the program counter.
            f.pc = (w == iwd_pkg::OP_RETURN) || (w == iwd_pkg::OP_IRQ_RETURN) ||
               (w[iwd_pkg::DEST_POS] && (w[6:0] == iwd_pkg::PC_LOW_FILE) && !f.nop); // see RULE2
         end
         iwd_pkg::IWD_CLS_BIT: begin
            f.skip = func[3]; // see RULE4
         end
         iwd_pkg::IWD_CLS_JUMP: begin
            f.pc = 1'b1;
         end
         iwd_pkg::IWD_CLS_LIT: begin
            f.pc = (func[3:2] == iwd_pkg::LIT_RETURN); // see RULE9
         end
         default: begin
            f = '0;
         end
      endcase
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Phase counter; it halts while asleep, since no phase clocks run then.
   assign advance = CLK_EN && cur_ff.run && (cur_ff.st == iwd_pkg::IWD_ST_RUN); // see RULE8

   iwd_phase_gen #(
      .PHASES(iwd_pkg::PHASES_PER_CYCLE)
   ) i_iwd_phase_gen (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .advance(advance),
      .phase(phase),
      .last(cycle_last)
   );

   assign fetch_fl = decode(PM_WORD);
   // A true skip, a PC change or a pending vector turns the next cycle into a no-operation.
   assign two_cycle = cur_ff.valid && (cur_ff.fl.pc || (cur_ff.fl.skip && COND_TRUE) || cur_ff.vec_pend);
   // A pending wake source makes the power-down word finish as a plain no-operation.
   assign enter_sleep = cur_ff.valid && cur_ff.fl.sleep && !WAKE_IRQ && !cur_ff.vec_pend;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state: pipeline, sleep control, pulses and APB slave.
   always_comb begin
      nxt_cur = cur_ff;
      if (CLK_EN) begin
         // Pulses end only on an enabled clock, so a frozen block keeps them as they stand.
         nxt_cur.wd_clr = 1'b0;
         nxt_cur.post_clr = 1'b0;
         nxt_cur.vec_req = 1'b0;
         case (cur_ff.st)
            iwd_pkg::IWD_ST_RUN: begin
               if (cycle_last) begin
                  // The word prefetched during this cycle becomes the one that executes next.
                  nxt_cur.word = PM_WORD; // see RULE12
                  nxt_cur.fl = fetch_fl; // see RULE1
                  nxt_cur.valid = !two_cycle; // see RULE6, see RULE7
                  if (cur_ff.valid && cur_ff.vec_pend) begin
                     nxt_cur.vec_pend = 1'b0;
                     nxt_cur.vec_req = 1'b1; // see RULE11
                  end
                  if (cur_ff.valid && (cur_ff.fl.kick || enter_sleep)) begin
                     nxt_cur.wd_clr = 1'b1; // see RULE10
                     nxt_cur.post_clr = cur_ff.post_assign; // see RULE10
                  end
                  if (enter_sleep) begin
                     nxt_cur.st = iwd_pkg::IWD_ST_SLEEP;
                  end
               end
            end
            iwd_pkg::IWD_ST_SLEEP: begin
               // The word after the power-down word is already held and runs on wake.
               if (WAKE_IRQ) begin
                  nxt_cur.st = iwd_pkg::IWD_ST_RUN;
                  nxt_cur.vec_pend = cur_ff.irq_en; // see RULE11
               end
            end
            default: begin
               nxt_cur.st = iwd_pkg::IWD_ST_RUN;
            end
         endcase
         // Read data and error are captured in the setup cycle so the access phase needs no wait.
         if (PSEL && !PENABLE) begin
            nxt_cur.slverr = 1'b0;
            case (PADDR)
               iwd_pkg::ADDR_CTRL: begin
                  nxt_cur.rdata = {29'h0000_0000, cur_ff.irq_en, cur_ff.post_assign, cur_ff.run};
               end
               iwd_pkg::ADDR_STATUS: begin
                  nxt_cur.rdata = {2'h0, cur_ff.word, 13'h0000, cur_ff.vec_pend, cur_ff.valid,
                     cur_ff.st == iwd_pkg::IWD_ST_SLEEP};
               end
               iwd_pkg::ADDR_FIELDS: begin
                  nxt_cur.rdata = {2'h0, cur_ff.fl.skip, cur_ff.fl.pc, 1'b0, IMM_CONST, 5'h00,
                     BIT_POS, RESULT_TO_FILE, REG_NUM};
               end
               default: begin
                  nxt_cur.rdata = 32'h0000_0000;
                  nxt_cur.slverr = 1'b1;
               end
            endcase
         end
         if (PSEL && PENABLE && PWRITE && (PADDR == iwd_pkg::ADDR_CTRL)) begin
            nxt_cur.run = PWDATA[iwd_pkg::CTRL_RUN_BIT];
            nxt_cur.post_assign = PWDATA[iwd_pkg::CTRL_POST_BIT];
            nxt_cur.irq_en = PWDATA[iwd_pkg::CTRL_IRQ_EN_BIT];
         end
      end
   end

   // All state resets to constants; the pipeline starts empty so the first cycle is a no-operation.
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cur_ff <= '0;
         cur_ff.run <= iwd_pkg::CTRL_RESET[iwd_pkg::CTRL_RUN_BIT];
         cur_ff.post_assign <= iwd_pkg::CTRL_RESET[iwd_pkg::CTRL_POST_BIT];
         cur_ff.irq_en <= iwd_pkg::CTRL_RESET[iwd_pkg::CTRL_IRQ_EN_BIT];
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operand fields are slices of the registered word, so they change only at cycle ends.
   assign EXEC_WORD = cur_ff.word; // see RULE1
   assign OP_CLASS = cur_ff.word[iwd_pkg::CLASS_MSB:iwd_pkg::CLASS_LSB]; // see RULE1
   assign REG_NUM = cur_ff.word[iwd_pkg::REG_LSB +: iwd_pkg::REG_W]; // see RULE3
   assign RESULT_TO_FILE = cur_ff.word[iwd_pkg::DEST_POS]; // see RULE2
   assign BIT_POS = cur_ff.word[iwd_pkg::BIT_LSB +: iwd_pkg::BIT_W]; // see RULE4
   assign IMM_WIDE = (OP_CLASS == iwd_pkg::IWD_CLS_JUMP); // see RULE5
   assign IMM_CONST = IMM_WIDE ? cur_ff.word[iwd_pkg::IMM_W-1:0] : {3'h0, cur_ff.word[iwd_pkg::LIT_W-1:0]};
   assign IS_SKIP = cur_ff.fl.skip;
   assign CHANGES_PC = cur_ff.fl.pc;
   assign EXEC_VALID = cur_ff.valid && (cur_ff.st == iwd_pkg::IWD_ST_RUN);
   assign ASLEEP = (cur_ff.st == iwd_pkg::IWD_ST_SLEEP);
   assign FETCH_STROBE = advance && (phase == 2'h0); // see RULE12
   assign Q_PHASE = phase;
   assign CYCLE_END = cycle_last;
   assign WATCHDOG_CLEAR = cur_ff.wd_clr;
   assign POSTSCALER_CLEAR = cur_ff.post_clr;
   assign VECTOR_REQ = cur_ff.vec_req;
   assign VECTOR_ADDR = iwd_pkg::IRQ_VECTOR;
   assign PRDATA = cur_ff.rdata;
   assign PREADY = 1'b1;
   assign PSLVERR = cur_ff.slverr && PSEL && PENABLE;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks of the decoded fields, the cycle timing, the watchdog clear and the wake vector.
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   property p_class_split;
      cycle_last |=> (OP_CLASS == $past(PM_WORD[13:12]));
   endproperty
   a_class_split: assert property (p_class_split) else $error("class code not taken from word"); // see RULE1

   property p_dest_bit;
      cycle_last |=> (RESULT_TO_FILE == $past(PM_WORD[7]));
   endproperty
   a_dest_bit: assert property (p_dest_bit) else $error("destination bit wrong"); // see RULE2

   property p_reg_num;
      cycle_last |=> (REG_NUM == $past(PM_WORD[6:0]));
   endproperty
   a_reg_num: assert property (p_reg_num) else $error("register number wrong"); // see RULE3

   property p_bit_pos;
      cycle_last |=> (BIT_POS == $past(PM_WORD[9:7]));
   endproperty
   a_bit_pos: assert property (p_bit_pos) else $error("bit position wrong"); // see RULE4

   property p_imm;
      cycle_last |=> (IMM_WIDE == ($past(PM_WORD[13:12]) == 2'h2)) &&
         (IMM_CONST == (IMM_WIDE ? $past(PM_WORD[10:0]) : {3'h0, $past(PM_WORD[7:0])}));
   endproperty
   a_imm: assert property (p_imm) else $error("literal width wrong"); // see RULE5

   property p_single;
      cycle_last && cur_ff.valid && !two_cycle |=> cur_ff.valid;
   endproperty
   a_single: assert property (p_single) else $error("single cycle word lost"); // see RULE6

   property p_two;
      cycle_last && two_cycle |=> !cur_ff.valid;
   endproperty
   a_two: assert property (p_two) else $error("second cycle not a no-operation"); // see RULE7

   property p_four;
      cycle_last |=> !cycle_last [*3];
   endproperty
   a_four: assert property (p_four) else $error("instruction cycle shorter than four clocks"); // see RULE8

   property p_dontcare;
      cycle_last |=> (cur_ff.fl.nop == (EXEC_WORD[13:7] == 7'h00 && EXEC_WORD[4:0] == 5'h00));
   endproperty
   a_dontcare: assert property (p_dontcare) else $error("don't-care bit changed decoding"); // see RULE9

   property p_kick;
      cycle_last && cur_ff.valid && cur_ff.fl.kick |=>
         WATCHDOG_CLEAR && (POSTSCALER_CLEAR == $past(cur_ff.post_assign));
   endproperty
   a_kick: assert property (p_kick) else $error("watchdog not cleared"); // see RULE10

   property p_wake_vec;
      ASLEEP && WAKE_IRQ && CLK_EN && cur_ff.irq_en |=> cur_ff.vec_pend && !VECTOR_REQ;
   endproperty
   a_wake_vec: assert property (p_wake_vec) else $error("vector not held for wake"); // see RULE11

   property p_fetch;
      FETCH_STROBE |-> !ASLEEP && (Q_PHASE == 2'h0);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch outside first phase"); // see RULE12

   c_two_cycle: cover property (cycle_last && two_cycle);
   c_sleep: cover property ($rose(ASLEEP));
   c_vector: cover property (VECTOR_REQ);
   c_kick: cover property (WATCHDOG_CLEAR && !ASLEEP);

endmodule // iwd_decoder

//--- bench/iwd_pm_model.sv
// Program memory model that feeds instruction words to the decoder.
// Assumes the decoder pulses fetch in phase 0 and samples the word at cycle end.
module iwd_pm_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic fetch,
   input wire logic cycle_end,
   input wire logic vector_req,
   input wire logic [12:0] vector_addr,
   output logic [13:0] word
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [13:0] mem [0:15];
   logic [3:0] pc_ff;
   logic [13:0] word_ff;
   logic valid_ff;

   // Fixed program image; branch targets are not followed, since PC arithmetic lives outside the block.
   initial begin
      mem = '{14'h0785, 14'h1683, 14'h30A5, 14'h0B8C, 14'h1D03, 14'h2808, 14'h3FFF, 14'h0064,
              14'h0060, 14'h0063, 14'h0A0E, 14'h0100, 14'h0000, 14'h0000, 14'h0000, 14'h0000};
   end

   ////////////////////////////////////////
   // Each fetch reads the next word, except that a vector request in the same cycle wins and restarts at the vector address.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_ff <= 4'h0;
         word_ff <= 14'h0000;
         valid_ff <= 1'b0;
      end else if (vector_req) begin
         word_ff <= mem[vector_addr[3:0]];
         pc_ff <= vector_addr[3:0] + 4'h1;
         valid_ff <= 1'b1;
      end else if (fetch) begin
         word_ff <= mem[pc_ff];
         pc_ff <= pc_ff + 4'h1;
         valid_ff <= 1'b1;
      end else if (cycle_end) begin
         valid_ff <= 1'b0;
      end
   end

   // Once the word has been taken the bus shows garbage, so a late sample cannot pass by luck.
   assign word = valid_ff ? word_ff : ~word_ff;
endmodule // iwd_pm_model

//--- bench/instruction_word_decoder_test.sv
// Self-checking bench for the instruction word decoder.
// Assumes the program image of the memory model and APB with zero wait states.
module instruction_word_decoder_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, cond_true = 1'b1, wake_irq = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, fetch_strobe, cycle_end, exec_valid, result_to_file, imm_wide;
   logic is_skip, changes_pc, wd_clear, ps_clear, asleep, vector_req, skip_gap = 1'b1;
   logic [13:0] pm_word, exec_word;
   logic [1:0] q_phase, op_class, ph;
   logic [6:0] reg_num;
   logic [2:0] bit_pos;
   logic [10:0] imm_const;
   logic [12:0] vector_addr;
   logic [14:0] rec [$];
   logic [13:0] exp_w [15] = '{14'h0000, 14'h0785, 14'h1683, 14'h30A5, 14'h0B8C, 14'h0000, 14'h2808,
                               14'h0000, 14'h0064, 14'h0060, 14'h0063, 14'h0A0E, 14'h0000, 14'h1D03, 14'h2808};
   logic exp_v [15] = '{0, 1, 1, 1, 1, 0, 1, 0, 1, 1, 1, 1, 0, 1, 1};
   int mismatches = 0, checks_done = 0, cycles = 0, gap = 0, n_wd = 0, n_ps = 0, n_vec = 0;

   iwd_decoder i_iwd_decoder (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PM_WORD(pm_word), .COND_TRUE(cond_true), .WAKE_IRQ(wake_irq),
      .FETCH_STROBE(fetch_strobe), .Q_PHASE(q_phase), .CYCLE_END(cycle_end), .EXEC_VALID(exec_valid),
      .EXEC_WORD(exec_word), .OP_CLASS(op_class), .REG_NUM(reg_num), .RESULT_TO_FILE(result_to_file),
      .BIT_POS(bit_pos), .IMM_CONST(imm_const), .IMM_WIDE(imm_wide), .IS_SKIP(is_skip),
      .CHANGES_PC(changes_pc), .WATCHDOG_CLEAR(wd_clear), .POSTSCALER_CLEAR(ps_clear), .ASLEEP(asleep),
      .VECTOR_REQ(vector_req), .VECTOR_ADDR(vector_addr));

   iwd_pm_model i_iwd_pm_model (.clk(core_clk), .rst(sys_rst), .fetch(fetch_strobe), .cycle_end(cycle_end),
      .vector_req(vector_req), .vector_addr(vector_addr), .word(pm_word));

   ////////////////////////////////////////
   // Clock, and a cycle ceiling that cuts a hang short.
   initial begin
      forever #(iwd_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         $display("BAD at %0t: run did not finish", $time);
         final_report();
      end
   end

   task check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("BAD at %0t: %s", $time, msg);
      end
   endtask

   task final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                 output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Only the bench's cycle ceiling ends a wait for the answer.
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Field expectations follow the word layout directly.
   task chk_fields(input logic [13:0] w);
      check(op_class === w[13:12], "class field");
      check(reg_num === w[6:0], "register number");
      check(result_to_file === w[7], "destination bit");
      check(bit_pos === w[9:7], "bit position");
      check(imm_const === ((w[13:12] == 2'h2) ? w[10:0] : {3'h0, w[7:0]}), "constant");
      check(imm_wide === (w[13:12] == 2'h2), "constant width");
      check(is_skip === (w == 14'h0B8C || w == 14'h1D03), "skip decode");
      check(changes_pc === (w[13:12] == 2'h2), "branch decode");
   endtask

   ////////////////////////////////////////
   // Monitor on the falling edge, where outputs are settled.
   always @(negedge core_clk) begin
      if (!sys_rst) begin
         if (clk_en && asleep === 1'b0) gap++;
         if (asleep === 1'b1) skip_gap = 1'b1;
         if (cycle_end === 1'b1 && asleep === 1'b0) begin
            check(q_phase === 2'h3, "cycle end phase");
            if (!skip_gap) check(gap == 4, "cycle length");
            gap = 0;
            skip_gap = 1'b0;
            if (rec.size() < 15) rec.push_back({exec_valid, exec_word});
            if (exec_valid === 1'b1) chk_fields(exec_word);
         end
         if (wd_clear === 1'b1) n_wd++;
         if (ps_clear === 1'b1) n_ps++;
         if (vector_req === 1'b1) begin
            n_vec++;
            check(vector_addr === 13'h0004, "vector address");
         end
      end
   end

   ////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      apb_xfer(1'b0, iwd_pkg::ADDR_CTRL, 32'h0000_0000, rd, er);
      check(rd === {29'h0000_0000, iwd_pkg::CTRL_RESET} && er === 1'b0, "control reset value");
      apb_xfer(1'b0, 8'h0C, 32'h0000_0000, rd, er);
      check(rd === 32'h0000_0000 && er === 1'b1, "unmapped read");
      apb_xfer(1'b1, iwd_pkg::ADDR_CTRL, 32'h0000_0007, rd, er);
      apb_xfer(1'b1, iwd_pkg::ADDR_STATUS, 32'hFFFF_FFFF, rd, er);
      check(er === 1'b0, "status write error");
      apb_xfer(1'b0, iwd_pkg::ADDR_CTRL, 32'h0000_0000, rd, er);
      check(rd === 32'h0000_0007, "control readback");
      $display("test registers done");
      for (int i = 0; i < 400 && asleep !== 1'b1; i++) @(posedge core_clk);
      cond_true <= 1'b0;
      repeat (8) @(posedge core_clk);
      check(asleep === 1'b1, "sleep entry");
      check(n_wd == 2 && n_ps == 2, "watchdog clears");
      wake_irq <= 1'b1;
      for (int i = 0; i < 50 && asleep !== 1'b0; i++) @(posedge core_clk);
      wake_irq <= 1'b0;
      for (int i = 0; i < 200 && rec.size() < 15; i++) @(posedge core_clk);
      check(rec.size() == 15, "cycle count");
      for (int i = 0; i < rec.size(); i++) begin
         if (exp_v[i]) check(rec[i] === {1'b1, exp_w[i]}, "executed word");
         else check(rec[i][14] === 1'b0, "no-op cycle");
      end
      check(n_vec == 1, "vector request");
      $display("test pipeline done");
      @(posedge core_clk);
      clk_en <= 1'b0;
      @(posedge core_clk);
      ph = q_phase;
      repeat (5) @(posedge core_clk);
      check(q_phase === ph, "phase frozen");
      clk_en <= 1'b1;
      repeat (12) @(posedge core_clk);
      $display("test clock enable done");
      final_report();
   end
endmodule // instruction_word_decoder_test
